// file: src/pwc_defs.svh
// Purpose: Offsets, field positions, select codes and response codes of the PWM channel block
// Assumes: Byte addresses on AXI4-Lite, one aligned word per register
// Notes:   Channel x registers sit at CH_BASE + (x << CH_LSB)
`ifndef PWC_DEFS_SVH
`define PWC_DEFS_SVH
// ----------------------------------------
// Global registers
// ----------------------------------------
`define PWC_OFS_DIV      12'h000
`define PWC_OFS_ENA      12'h004
`define PWC_OFS_DIS      12'h008
`define PWC_OFS_SR       12'h00C
`define PWC_OFS_IEN      12'h010
`define PWC_OFS_ISR      12'h01C
`define PWC_OFS_ICLR     12'h020
// ----------------------------------------
// Channel registers
// ----------------------------------------
`define PWC_CH_BASE      12'h200
`define PWC_CH_LSB       5
`define PWC_OFS_CMODE    5'h00
`define PWC_OFS_CDUTY    5'h04
`define PWC_OFS_CPER     5'h08
`define PWC_OFS_CCNT     5'h0C
`define PWC_OFS_UBUF     5'h10
// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define PWC_DIV_A_LSB    0
`define PWC_DIV_B_LSB    16
`define PWC_CODE_CLK_A   4'hB
`define PWC_CODE_CLK_B   4'hC
`define PWC_RESP_OKAY    2'h0
`define PWC_RESP_SLVERR  2'h2
`endif

// file: src/pwc_pkg.sv
// Purpose: Types shared by the PWM channel block
// Assumes: 16-bit channel counter
// Notes:   Field order of pwc_cfg_t matches the channel mode register
package pwc_pkg;
  typedef struct packed {
    logic       upd_tgt;
    logic       start_hi;
    logic       center;
    logic [3:0] clk_sel;
  } pwc_cfg_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic        down;
    logic        pend;
    logic [15:0] upd;
  } pwc_st_t;
endpackage

// file: src/pwc_top.sv
// Purpose: Multi-channel PWM counter, duty, period and double-buffered update
// Assumes: AXI4-Lite slave, single clock aclk, synchronous active-low reset
// Notes:   Only the low 16 bits of period, duty and update words are kept
//
// Contract
// R1: Software keeps duty between zero and the period value inclusive.
// R2: Period, duty, update words are 32 bits; only the low 16 bits are used.
// R3: Prescaled left period is factor times period over master clock, factor 1..1024.
// R4: Divider-clocked left period is period times divider setting over master clock; only the low 8 bits of each 16-bit setting are used.
// R5: Center-aligned period is twice the left-aligned period.
// R6: Counter register is read-only, live, and cleared when the channel is enabled.
// R7: Left-aligned counter returns to zero on reaching the period, new period.
// R8: Update register writes are buffered, never applied at once.
// R9: Update target 0 copies the buffer into duty at the next period start.
// R10: Update target 1 copies the buffer into period at the next period start.
// R11: Alignment bit 0 gives left-aligned, 1 center-aligned periods.
// R12: Start level bit 0 starts each period low, 1 starts high.
// R13: Clock select 0..10 divides by 2^code, 11 clock A, 12 clock B, else none.
// R14: A per-channel flag sets each new period; reading the status clears them.
// R15: Center-aligned counter sweeps up to the period then back down to zero.
// R16: Output leaves start level on duty match, mirrored on the down-count.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pwc_defs.svh"
module pwc_top
  import pwc_pkg::*;
#(
  parameter int N_CH = 4
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [N_CH-1:0]        pwm_out,
  output logic                   irq
);
  // ----------------------------------------
  // Bus slave state
  // ----------------------------------------
  logic        aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
  logic [11:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
  logic        wr_go, rd_go, ch_wsel, ch_rsel;
  logic [4:0]  wofs, rofs;
  logic [1:0]  wch, rch;
  logic [15:0] div_a_ff, nxt_div_a, div_b_ff, nxt_div_b;
  logic [7:0]  dva_cnt_ff, nxt_dva_cnt, dvb_cnt_ff, nxt_dvb_cnt;
  logic [9:0]  pre_ff, nxt_pre;
  logic        tick_a, tick_b, awrdy_ff, nxt_awrdy, wrdy_ff, nxt_wrdy, arrdy_ff, nxt_arrdy;
  logic [N_CH-1:0] ena_ff, nxt_ena, ien_ff, nxt_ien, isr_ff, nxt_isr;
  logic [N_CH-1:0] evt, ena_hit, pout_ff;
  logic        irq_ff, nxt_irq;
  pwc_cfg_t    cfg_ff [N_CH];
  logic [15:0] dty_ff [N_CH];
  logic [15:0] prd_ff [N_CH];
  pwc_st_t     st_ff  [N_CH];

  assign s_axi_awready = awrdy_ff;
  assign s_axi_wready  = wrdy_ff;
  assign s_axi_bvalid  = b_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = arrdy_ff;
  assign s_axi_rvalid  = r_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  assign pwm_out       = pout_ff;
  assign irq           = irq_ff;

  assign wr_go   = aw_ff & w_ff & ~b_ff;
  assign rd_go   = s_axi_arvalid & ~r_ff;
  assign ch_wsel = awa_ff[11:9] == 3'(`PWC_CH_BASE >> 9);
  assign ch_rsel = s_axi_araddr[11:9] == 3'(`PWC_CH_BASE >> 9);
  assign wofs    = awa_ff[4:0];
  assign rofs    = s_axi_araddr[4:0];
  assign wch     = awa_ff[`PWC_CH_LSB+:2];
  assign rch     = s_axi_araddr[`PWC_CH_LSB+:2];
  // Clock A/B ticks: period = low 8 bits of setting in master cycles, 0 in those bits stops the clock
  assign tick_a  = (div_a_ff[7:0] != 8'h00) && (dva_cnt_ff == div_a_ff[7:0] - 8'h01); // see R4
  assign tick_b  = (div_b_ff[7:0] != 8'h00) && (dvb_cnt_ff == div_b_ff[7:0] - 8'h01); // see R4

  always_comb
  begin
    nxt_aw = aw_ff;  nxt_awa = awa_ff;
    nxt_w = w_ff;    nxt_wd = wd_ff;
    nxt_b = b_ff;    nxt_br = br_ff;
    nxt_r = r_ff;    nxt_rd = rd_ff;  nxt_rr = rr_ff;
    nxt_div_a = div_a_ff;  nxt_div_b = div_b_ff;
    nxt_ena = ena_ff;    nxt_ien = ien_ff;  nxt_isr = isr_ff;
    nxt_pre = pre_ff + 10'h001;
    nxt_dva_cnt = tick_a || div_a_ff[7:0] == 8'h00 ? 8'h00 : dva_cnt_ff + 8'h01;
    nxt_dvb_cnt = tick_b || div_b_ff[7:0] == 8'h00 ? 8'h00 : dvb_cnt_ff + 8'h01;
    if (s_axi_awvalid && !aw_ff)
    begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff)
    begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
    end
    if (b_ff && s_axi_bready)
      nxt_b = 1'b0;
    if (r_ff && s_axi_rready)
      nxt_r = 1'b0;
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_b = 1'b1;
      nxt_br = `PWC_RESP_OKAY;
      case (awa_ff)
        `PWC_OFS_DIV:  {nxt_div_b, nxt_div_a} = wd_ff;
        `PWC_OFS_ENA:  nxt_ena = ena_ff | wd_ff[N_CH-1:0];
        `PWC_OFS_DIS:  nxt_ena = ena_ff & ~wd_ff[N_CH-1:0];
        `PWC_OFS_IEN:  nxt_ien = wd_ff[N_CH-1:0];
        `PWC_OFS_ICLR: nxt_isr = isr_ff & ~wd_ff[N_CH-1:0];
        default:
          if (!(ch_wsel && 32'(wch) < N_CH && wofs[1:0] == 2'h0 && wofs <= `PWC_OFS_UBUF))
            nxt_br = `PWC_RESP_SLVERR;
      endcase
    end
    if (rd_go)
    begin
      nxt_r = 1'b1;
      nxt_rr = `PWC_RESP_OKAY;
      nxt_rd = 32'h0;
      case (s_axi_araddr)
        `PWC_OFS_DIV: nxt_rd = {div_b_ff, div_a_ff};
        `PWC_OFS_SR:  nxt_rd[N_CH-1:0] = ena_ff;
        `PWC_OFS_IEN: nxt_rd[N_CH-1:0] = ien_ff;
        `PWC_OFS_ISR:
        begin
          nxt_rd[N_CH-1:0] = isr_ff;
          nxt_isr = '0; // see R14
        end
        default:
          if (ch_rsel && 32'(rch) < N_CH)
            case (rofs)
              `PWC_OFS_CMODE: nxt_rd[10:0] = {cfg_ff[rch][6:4], 4'h0, cfg_ff[rch].clk_sel};
              `PWC_OFS_CDUTY: nxt_rd[15:0] = dty_ff[rch]; // see R2
              `PWC_OFS_CPER:  nxt_rd[15:0] = prd_ff[rch]; // see R2
              `PWC_OFS_CCNT:  nxt_rd[15:0] = st_ff[rch].cnt; // see R6
              default:        nxt_rr = `PWC_RESP_SLVERR;
            endcase
          else
            nxt_rr = `PWC_RESP_SLVERR;
      endcase
    end
    // A new period in the clearing cycle still leaves its flag set
    nxt_isr = nxt_isr | evt; // see R14
    nxt_irq = |(nxt_isr & nxt_ien);  nxt_awrdy = ~nxt_aw;  nxt_wrdy = ~nxt_w;  nxt_arrdy = ~nxt_r;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_ff <= 1'b0;  awa_ff <= 12'h000;  awrdy_ff <= 1'b1;
      w_ff <= 1'b0;   wd_ff <= 32'h0;  wrdy_ff <= 1'b1;
      b_ff <= 1'b0;   br_ff <= 2'h0;
      r_ff <= 1'b0;   rd_ff <= 32'h0;  rr_ff <= 2'h0;  arrdy_ff <= 1'b1;
      div_a_ff <= 16'h0;  div_b_ff <= 16'h0;
      dva_cnt_ff <= 8'h00;  dvb_cnt_ff <= 8'h00;  pre_ff <= 10'h000;
      ena_ff <= '0;  ien_ff <= '0;  isr_ff <= '0;  irq_ff <= 1'b0;
    end
    else
    begin
      aw_ff <= nxt_aw;  awa_ff <= nxt_awa;  awrdy_ff <= nxt_awrdy;
      w_ff <= nxt_w;    wd_ff <= nxt_wd;  wrdy_ff <= nxt_wrdy;
      b_ff <= nxt_b;    br_ff <= nxt_br;
      r_ff <= nxt_r;    rd_ff <= nxt_rd;  rr_ff <= nxt_rr;  arrdy_ff <= nxt_arrdy;
      div_a_ff <= nxt_div_a;  div_b_ff <= nxt_div_b;
      dva_cnt_ff <= nxt_dva_cnt;  dvb_cnt_ff <= nxt_dvb_cnt;  pre_ff <= nxt_pre;
      ena_ff <= nxt_ena;  ien_ff <= nxt_ien;  isr_ff <= nxt_isr;  irq_ff <= nxt_irq;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  for (genvar gi = 0; gi < N_CH; gi++)
  begin : g_ch
    pwc_cfg_t    nxt_cfg;
    pwc_st_t     nxt_st;
    logic [15:0] nxt_dty, nxt_prd;
    logic [10:0] pmask;
    logic        tick, sel, nxt_out;

    assign sel = wr_go && ch_wsel && 32'(wch) == gi;
    assign ena_hit[gi] = wr_go && awa_ff == `PWC_OFS_ENA && wd_ff[gi];
    // Power-of-two prescale taps one shared counter, so all channels stay phase aligned
    assign pmask = (11'h001 << cfg_ff[gi].clk_sel) - 11'h001;
    always_comb
    begin
      case (cfg_ff[gi].clk_sel)
        `PWC_CODE_CLK_A: tick = tick_a; // see R13
        `PWC_CODE_CLK_B: tick = tick_b; // see R13
        default: tick = cfg_ff[gi].clk_sel < `PWC_CODE_CLK_A
                        && ({1'b0, pre_ff} & pmask) == pmask; // see R3
      endcase
    end

    always_comb
    begin
      nxt_cfg = cfg_ff[gi];
      nxt_dty = dty_ff[gi];
      nxt_prd = prd_ff[gi];
      nxt_st  = st_ff[gi];
      evt[gi] = 1'b0;
      if (ena_hit[gi])
      begin
        nxt_st.cnt = 16'h0; // see R6
        nxt_st.down = 1'b0;
      end
      else if (ena_ff[gi] && tick)
      begin
        if (!cfg_ff[gi].center) // see R11
        begin
          if (st_ff[gi].cnt + 17'h1 >= 17'(prd_ff[gi])) // Wrap early: a period spans period_value ticks
          begin
            nxt_st.cnt = 16'h0; // see R7
            evt[gi] = 1'b1;
          end
          else
            nxt_st.cnt = st_ff[gi].cnt + 16'h1;
        end
        else if (!st_ff[gi].down)
        begin
          if (st_ff[gi].cnt >= prd_ff[gi])
          begin
            nxt_st.down = 1'b1; // see R15
            nxt_st.cnt = prd_ff[gi] == 16'h0 ? 16'h0 : prd_ff[gi] - 16'h1;
          end
          else
            nxt_st.cnt = st_ff[gi].cnt + 16'h1;
        end
        else if (st_ff[gi].cnt == 16'h0)
        begin
          // Two sweeps per period double the left-aligned period
          nxt_st.down = 1'b0; // see R5
          nxt_st.cnt = prd_ff[gi] == 16'h0 ? 16'h0 : 16'h1;
          evt[gi] = 1'b1;
        end
        else
          nxt_st.cnt = st_ff[gi].cnt - 16'h1;
      end
      if (evt[gi] && st_ff[gi].pend)
      begin
        nxt_st.pend = 1'b0;
        if (cfg_ff[gi].upd_tgt)
          nxt_prd = st_ff[gi].upd; // see R10
        else
          nxt_dty = st_ff[gi].upd; // see R9
      end
      if (sel)
        case (wofs)
          `PWC_OFS_CMODE: nxt_cfg = {wd_ff[10:8], wd_ff[3:0]};
          `PWC_OFS_CDUTY: nxt_dty = wd_ff[15:0]; // see R2
          `PWC_OFS_CPER:  nxt_prd = wd_ff[15:0]; // see R2
          `PWC_OFS_UBUF:
          begin
            nxt_st.upd = wd_ff[15:0]; // see R8
            nxt_st.pend = 1'b1;
          end
          default: ;
        endcase
      // Duty above period is unsupported; output then never leaves start level
      nxt_out = nxt_ena[gi] && nxt_st.cnt >= nxt_dty ? ~nxt_cfg.start_hi : nxt_cfg.start_hi; // see R12 R16 R1
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        cfg_ff[gi]  <= '0;
        dty_ff[gi]  <= 16'h0;
        prd_ff[gi]  <= 16'h0;
        st_ff[gi]   <= '0;
        pout_ff[gi] <= 1'b0;
      end
      else
      begin
        cfg_ff[gi]  <= nxt_cfg;
        dty_ff[gi]  <= nxt_dty;
        prd_ff[gi]  <= nxt_prd;
        st_ff[gi]   <= nxt_st;
        pout_ff[gi] <= nxt_out;
      end
    end

    sequence s_upd_due;
      evt[gi] && st_ff[gi].pend && !sel;
    endsequence
    sequence s_left_wrap;
      ena_ff[gi] && tick && !cfg_ff[gi].center && st_ff[gi].cnt + 17'h1 >= 17'(prd_ff[gi]) && !ena_hit[gi];
    endsequence

    a_enable_clears: assert property (@(posedge aclk) disable iff (!aresetn) // see R6
      ena_hit[gi] |=> st_ff[gi].cnt == 16'h0 && !st_ff[gi].down) else $error("enable did not clear counter");
    a_left_wrap: assert property (@(posedge aclk) disable iff (!aresetn) // see R7
      s_left_wrap |=> st_ff[gi].cnt == 16'h0 ##0 $past(evt[gi])) else $error("left counter did not wrap");
    a_upd_to_duty: assert property (@(posedge aclk) disable iff (!aresetn) // see R9
      s_upd_due ##0 !cfg_ff[gi].upd_tgt |=> dty_ff[gi] == $past(st_ff[gi].upd) && !st_ff[gi].pend)
      else $error("duty not updated at period start");
    a_upd_to_period: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
      s_upd_due ##0 cfg_ff[gi].upd_tgt |=> prd_ff[gi] == $past(st_ff[gi].upd))
      else $error("period not updated at period start");
    a_upd_buffered: assert property (@(posedge aclk) disable iff (!aresetn) // see R8
      sel && wofs == `PWC_OFS_UBUF && !evt[gi] |=> $stable(dty_ff[gi]) && $stable(prd_ff[gi]) && st_ff[gi].pend)
      else $error("update applied without period start");
    a_center_turn: assert property (@(posedge aclk) disable iff (!aresetn) // see R15
      ena_ff[gi] && tick && cfg_ff[gi].center && !st_ff[gi].down && st_ff[gi].cnt >= prd_ff[gi]
      && !ena_hit[gi] |=> st_ff[gi].down) else $error("center counter did not turn down");
    a_out_level: assert property (@(posedge aclk) disable iff (!aresetn) // see R16
      ena_ff[gi] && $stable(cfg_ff[gi]) |-> pout_ff[gi] ==
      (st_ff[gi].cnt < dty_ff[gi] ? cfg_ff[gi].start_hi : ~cfg_ff[gi].start_hi))
      else $error("output level does not follow duty");
    a_flag_set: assert property (@(posedge aclk) disable iff (!aresetn) // see R14
      evt[gi] |=> isr_ff[gi]) else $error("period flag not set");
  end

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_ff == |(isr_ff & ien_ff)) else $error("interrupt level mismatch");
endmodule // pwc_top

// file: verification/pwc_top_bench.sv
// Purpose: Self-checking bench for the PWM channel block, channel 0
// Assumes: Bus tasks wait on every handshake; duty never above period
// Notes:   Periods are timed between rising edges of the channel output
`timescale 1ns/1ps
`include "pwc_defs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module pwc_top_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam logic [11:0] CMODE = `PWC_CH_BASE + `PWC_OFS_CMODE;
  localparam logic [11:0] CDUTY = `PWC_CH_BASE + `PWC_OFS_CDUTY;
  localparam logic [11:0] CPER  = `PWC_CH_BASE + `PWC_OFS_CPER;
  localparam logic [11:0] CCNT  = `PWC_CH_BASE + `PWC_OFS_CCNT;
  localparam logic [11:0] UBUF  = `PWC_CH_BASE + `PWC_OFS_UBUF;
  logic        aclk, aresetn, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd, d;
  logic [1:0]  br, rr, r;
  logic [3:0]  pwm;
  int          n_mismatch, check_count, c;

  pwc_top #(.N_CH(4)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .pwm_out(pwm), .irq(irq));

  // ----------------------------------------
  // Bus and timing tasks
  // ----------------------------------------
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end
    while (!bv && n < 100);
    r = br;
    brdy <= 1'b0;
    if (n >= 100) n_mismatch++;
  endtask

  task automatic rd_reg(input logic [11:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arv && arr) arv <= 1'b0;
    end
    while (!rv && n < 100);
    d = rd;
    r = rr;
    rrdy <= 1'b0;
    if (n >= 100) n_mismatch++;
  endtask

  // Two rising edges: the first syncs, the second gives one full period
  task automatic meas();
    logic p, q;
    q = pwm[0];
    for (int k = 0; k < 2; k++)
    begin
      c = 0;
      do
      begin
        @(posedge aclk);
        p = q;
        q = pwm[0];
        c++;
      end
      while (!(q && !p) && c < 5000);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd_reg(CPER);
    `CHK(d, 32'h0000_0000);
    wr_reg(CPER, 32'hABCD_5678);
    `CHK(r, `PWC_RESP_OKAY);
    rd_reg(CPER);
    `CHK({r, d}, {`PWC_RESP_OKAY, 32'h0000_5678});
    rd_reg(UBUF);
    `CHK(r, `PWC_RESP_SLVERR);
    rd_reg(12'h100);
    `CHK({r, d}, {`PWC_RESP_SLVERR, 32'h0});
    wr_reg(12'h100, 32'h0000_0001);
    `CHK(r, `PWC_RESP_SLVERR);
    wr_reg(CCNT, 32'h0000_1234);
    rd_reg(CCNT);
    `CHK(d, 32'h0000_0000);
    wr_reg(CMODE, 32'h0000_0200);
    repeat (3) @(posedge aclk);
    `CHK(pwm[0], 1'b1);
    `CHK(pwm[3:1], 3'h0);
    wr_reg(CMODE, 32'h0000_0000);
    repeat (3) @(posedge aclk);
    `CHK(pwm[0], 1'b0);
  endtask

  // Every clock source kind, both alignments; divider A is 3, divider B is 2
  task automatic t_period();
    int sel[5] = '{0, 2, 1, 11, 12};
    int ctr[5] = '{0, 0, 1, 0, 1};
    int fac[5] = '{1, 4, 2, 3, 2};
    wr_reg(`PWC_OFS_DIV, 32'h0002_0003);
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(CMODE, 32'(ctr[i] * 256 + sel[i]));
      wr_reg(CPER, 32'h5);
      wr_reg(CDUTY, 32'h2);
      wr_reg(`PWC_OFS_ENA, 32'h1);
      meas();
      `CHK(32'(c), 32'((ctr[i] + 1) * fac[i] * 5));
      wr_reg(`PWC_OFS_DIS, 32'h1);
    end
  endtask

  // Updates land only at a period start; slow clock leaves room after sync
  task automatic t_update();
    wr_reg(CMODE, 32'h0000_0004);
    wr_reg(CPER, 32'h5);
    wr_reg(CDUTY, 32'h2);
    wr_reg(`PWC_OFS_ENA, 32'h1);
    meas();
    wr_reg(UBUF, 32'h0000_0003);
    rd_reg(CDUTY);
    `CHK(d, 32'h0000_0002);
    meas();
    rd_reg(CDUTY);
    `CHK(d, 32'h0000_0003);
    wr_reg(CMODE, 32'h0000_0404);
    wr_reg(UBUF, 32'h0000_0007);
    rd_reg(CPER);
    `CHK(d, 32'h0000_0005);
    meas();
    rd_reg(CPER);
    `CHK(d, 32'h0000_0007);
    meas();
    `CHK(32'(c), 32'(16 * 7));
    wr_reg(`PWC_OFS_DIS, 32'h1);
  endtask

  task automatic t_irq();
    wr_reg(CMODE, 32'h0000_0000);
    wr_reg(CPER, 32'd40);
    wr_reg(CDUTY, 32'd20);
    wr_reg(`PWC_OFS_ENA, 32'h1);
    repeat (100) @(posedge aclk);
    `CHK(irq, 1'b0);
    wr_reg(`PWC_OFS_IEN, 32'h1);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge aclk);
    `CHK(irq, 1'b1);
    wr_reg(`PWC_OFS_DIS, 32'h1);
    rd_reg(`PWC_OFS_ISR);
    `CHK(d[0], 1'b1);
    rd_reg(`PWC_OFS_ISR);
    `CHK(d[3:0], 4'h0);
    repeat (3) @(posedge aclk);
    `CHK(irq, 1'b0);
    // Reserved select never ticks, so only the enable can move the counter
    wr_reg(CMODE, 32'h0000_000D);
    wr_reg(`PWC_OFS_ENA, 32'h1);
    rd_reg(CCNT);
    `CHK(d, 32'h0000_0000);
    // Let the channel run again so the clear register has a flag to clear
    wr_reg(CMODE, 32'h0000_0000);
    repeat (100) @(posedge aclk);
    `CHK(irq, 1'b1);
    wr_reg(`PWC_OFS_DIS, 32'h1);
    wr_reg(`PWC_OFS_ICLR, 32'hF);
    rd_reg(`PWC_OFS_ISR);
    `CHK(d[3:0], 4'h0);
    `CHK(irq, 1'b0);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, reset, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {aresetn, awv, wv, brdy, arv, rrdy} = '0;
    {awa, ara, wd} = '0;
    n_mismatch = 0;
    check_count = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_period();
    t_update();
    t_irq();
    wrap_up();
  end
endmodule // pwc_top_bench
